/* hw/pls_synth.sv */
// Purpose: programmable divider, reference divider, phase outputs and lock flags
// Assumes: xtal_tick pulses once per 75 kHz period; band inputs are sampled levels
// Notes: ports are reached by io_wr/io_rd with a channel code, one nibble each
`timescale 1ns/1ns

// Functional notes
// R1 - swallow division number is 16 bits, software keeps it in 210H..FFFFH
// R2 - direct mode counts 12 bits; low four bits ignored, bit four is lsb
// R3 - programmed value used without offset; predivider scales it by 4 or 8
// R4 - swallow divider is 4-bit swallow counter steering prescaler, then 12-bit counter
// R5 - divide-by-four ahead in FM band, divide-by-eight in VHF/TV band
// R6 - unselected band input pulled down; both pulled down while PLL is off
// R7 - seven reference frequencies divided from the crystal clock
// R8 - all-ones reference code turns PLL off and halts counters
// R9 - software writes reference select on channel three
// R10 - comparator drives phase difference on two tri-state outputs
// R11 - primary output may be a general output or forced to high impedance
// R12 - sticky unlock flag set when phase misaligned at half reference period
// R13 - writing one to lock clear clears unlock flag and valid bit
// R14 - valid only after a full reference cycle; software checks before reading
// R15 - 3-bit phase bin in 13.3 us steps, top bit reads zero
// R16 - phase bin updated continuously within plus/minus half reference period
// R17 - at 25 and 12.5 kHz bin cannot resolve beyond half a period
// R18 - software uses channels seven and eight for output control and status
// R19 - PLL off floats both outputs except primary used as general output
// R20 - whole division number takes effect when top nibble written at select three
// R21 - nibble select advances by one on every data port access
// R22 - mode bit zero picks direct from low band, one picks swallow high band
// R23 - swallow mode offsets division by plus or minus one; both set inhibited
// R24 - each reference frequency has a distinct code; all ones is off
// R25 - output high when divider lags, low when it leads, else floating
module pls_synth
  import pls_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic xtal_tick,
  input wire logic low_band_input,
  input wire logic high_band_input,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [3:0] io_chan,
  input wire logic [3:0] io_wdata,
  output logic [3:0] io_rdata,
  output logic prescaler_mod_ctrl,
  output logic low_band_pulldown,
  output logic high_band_pulldown,
  output logic phase_out_primary_o,
  output logic phase_out_primary_oe,
  output logic phase_out_secondary_o,
  output logic phase_out_secondary_oe
);
  pls_mode_s mode_q;
  pls_do1_s do1_q;
  logic [1:0] nsel_q;
  logic [3:0] stage_q [4];
  logic [15:0] div_n_q;
  logic [3:0] ref_sel_q;
  logic [1:0] pre_q;
  logic pll_off;
  logic wr_ndata;
  logic acc_ndata;
  logic lock_clr;

  assign pll_off = (ref_sel_q == REF_OFF); // R8 R24
  assign wr_ndata = io_wr && (io_chan == CH_NDATA);
  assign acc_ndata = (io_wr || io_rd) && (io_chan == CH_NDATA);
  assign lock_clr = io_wr && (io_chan == CH_LOCK) && io_wdata[0];

  // control ports written by the output instruction group
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_RST;
      ref_sel_q <= REF_RST;
      pre_q <= PRE_NONE;
      do1_q <= DO1_RST;
    end
    else if (io_wr)
    begin
      case (io_chan)
        CH_MODE: mode_q <= io_wdata[2:0]; // R22
        CH_REF: ref_sel_q <= io_wdata; // R9
        CH_PRE: pre_q <= io_wdata[1:0];
        CH_DO1: do1_q <= io_wdata[2:0]; // R11 R18
        default: ;
      endcase
    end
  end

  // nibbles are staged; the top nibble commits all sixteen bits at once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nsel_q <= 2'h0;
      div_n_q <= DIV_RST;
      for (int i = 0; i < 4; i++)
        stage_q[i] <= 4'h0;
    end
    else
    begin
      if (io_wr && io_chan == CH_NSEL)
        nsel_q <= io_wdata[1:0];
      else if (acc_ndata)
        nsel_q <= nsel_q + 2'h1; // R21
      if (wr_ndata)
        stage_q[nsel_q] <= io_wdata;
      if (wr_ndata && nsel_q == NSEL_TOP)
        div_n_q <= {io_wdata, stage_q[2], stage_q[1], stage_q[0]}; // R20
    end
  end

  // reference divider from crystal ticks; half point drives the lock check
  logic [6:0] ref_div;
  logic [6:0] ref_cnt_q;
  logic ref_pulse_q;
  logic half_pulse_q;

  assign ref_div = pls_ref_div(ref_sel_q); // R7 R24

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_cnt_q <= 7'h0;
      ref_pulse_q <= 1'b0;
      half_pulse_q <= 1'b0;
    end
    else if (pll_off)
    begin
      ref_cnt_q <= 7'h0; // R8
      ref_pulse_q <= 1'b0;
      half_pulse_q <= 1'b0;
    end
    else
    begin
      ref_pulse_q <= xtal_tick && (ref_cnt_q == ref_div - 7'h1); // R7
      half_pulse_q <= xtal_tick && (ref_cnt_q == {1'b0, ref_div[6:1]}); // R12
      if (xtal_tick)
        ref_cnt_q <= (ref_cnt_q >= ref_div - 7'h1) ? 7'h0 : ref_cnt_q + 7'h1;
    end
  end

  // band input edges; the predivider sits ahead of the swallow section
  logic low_prev_q;
  logic high_prev_q;
  logic [2:0] pre_cnt_q;
  logic low_edge;
  logic high_edge;
  logic pre_hit;
  logic [2:0] pre_top;

  assign low_edge = low_band_input && !low_prev_q;
  assign high_edge = high_band_input && !high_prev_q;
  assign pre_top = (pre_q == PRE_DIV8) ? 3'h7 : (pre_q == PRE_DIV4) ? 3'h3 : 3'h0; // R5
  assign pre_hit = high_edge && (pre_cnt_q == pre_top);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_prev_q <= 1'b0;
      high_prev_q <= 1'b0;
      pre_cnt_q <= 3'h0;
    end
    else
    begin
      low_prev_q <= low_band_input;
      high_prev_q <= high_band_input;
      if (pll_off || !mode_q.swallow)
        pre_cnt_q <= 3'h0;
      else if (high_edge)
        pre_cnt_q <= pre_hit ? 3'h0 : pre_cnt_q + 3'h1; // R5 R3
    end
  end

  // division number with the IF offset; both offset bits set means none
  logic [15:0] n_eff;
  logic [11:0] main_load;
  logic [3:0] swl_load;
  logic cnt_pulse;

  always_comb
  begin
    n_eff = div_n_q; // R3
    if (mode_q.if_up && !mode_q.if_dn)
      n_eff = div_n_q + 16'h1; // R23
    else if (mode_q.if_dn && !mode_q.if_up)
      n_eff = div_n_q - 16'h1; // R23
    if (!mode_q.swallow)
    begin
      main_load = div_n_q[15:4]; // R2
      swl_load = 4'h0;
    end
    else
    begin
      main_load = n_eff[15:4]; // R1 R4
      swl_load = n_eff[3:0]; // R4
    end
    cnt_pulse = mode_q.swallow ? pre_hit : low_edge; // R22
  end

  logic [11:0] main_cnt_q;
  logic [3:0] swl_cnt_q;
  logic div_pulse_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_cnt_q <= 12'h0;
      swl_cnt_q <= 4'h0;
      div_pulse_q <= 1'b0;
    end
    else if (pll_off)
    begin
      main_cnt_q <= main_load; // R8
      swl_cnt_q <= swl_load;
      div_pulse_q <= 1'b0;
    end
    else
    begin
      div_pulse_q <= cnt_pulse && (main_cnt_q <= 12'h1);
      if (cnt_pulse)
      begin
        if (main_cnt_q <= 12'h1)
        begin
          main_cnt_q <= main_load; // R4
          swl_cnt_q <= swl_load;
        end
        else
        begin
          main_cnt_q <= main_cnt_q - 12'h1;
          if (swl_cnt_q != 4'h0)
            swl_cnt_q <= swl_cnt_q - 4'h1; // R4
        end
      end
    end
  end

  logic up;
  logic dn;
  logic [2:0] bin;

  pls_phase_det u_det (
    .clk(clk),
    .rst_n(rst_n),
    .run(!pll_off),
    .ref_pulse(ref_pulse_q),
    .div_pulse(div_pulse_q),
    .up_q(up),
    .dn_q(dn),
    .bin_q(bin)
  );

  // unlock is sticky; a set in the clearing cycle wins over the clear
  logic unlock_q;
  logic valid_q;
  logic seen_q;
  logic unlock_set;

  assign unlock_set = half_pulse_q && (up || dn); // R12 R17

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unlock_q <= 1'b0;
    else if (unlock_set)
      unlock_q <= 1'b1; // R12
    else if (lock_clr)
      unlock_q <= 1'b0; // R13
  end

  // two reference edges after the clear guarantee one whole period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else if (lock_clr)
    begin
      valid_q <= 1'b0; // R13
      seen_q <= 1'b0;
    end
    else if (ref_pulse_q)
    begin
      seen_q <= 1'b1;
      if (seen_q)
        valid_q <= 1'b1; // R14
    end
  end

  // tri-state drivers and pull-downs, all registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_out_primary_o <= 1'b0;
      phase_out_primary_oe <= 1'b0;
      phase_out_secondary_o <= 1'b0;
      phase_out_secondary_oe <= 1'b0;
      low_band_pulldown <= 1'b1;
      high_band_pulldown <= 1'b1;
      prescaler_mod_ctrl <= 1'b0;
    end
    else
    begin
      if (do1_q.gen_out)
      begin
        phase_out_primary_o <= do1_q.level; // R11 R19
        phase_out_primary_oe <= 1'b1;
      end
      else
      begin
        phase_out_primary_o <= up; // R10 R25
        phase_out_primary_oe <= (up || dn) && !do1_q.hiz && !pll_off; // R11 R19
      end
      phase_out_secondary_o <= up; // R10 R25
      phase_out_secondary_oe <= (up || dn) && !pll_off; // R19
      low_band_pulldown <= pll_off || mode_q.swallow; // R6
      high_band_pulldown <= pll_off || !mode_q.swallow; // R6
      prescaler_mod_ctrl <= mode_q.swallow && (swl_cnt_q != 4'h0); // R4
    end
  end

  // readback through the input instruction group
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      io_rdata <= 4'h0;
    else if (io_rd)
    begin
      case (io_chan)
        CH_MODE: io_rdata <= {1'b0, mode_q};
        CH_NSEL: io_rdata <= {2'h0, nsel_q};
        CH_NDATA: io_rdata <= stage_q[nsel_q];
        CH_REF: io_rdata <= ref_sel_q;
        CH_PRE: io_rdata <= {2'h0, pre_q};
        CH_DO1: io_rdata <= {2'h0, valid_q, unlock_q}; // R14 R18
        CH_LOCK: io_rdata <= {1'b0, bin}; // R15 R18
        default: io_rdata <= 4'h0;
      endcase
    end
  end

  a_nibble_commit: assert property (@(posedge clk) disable iff (!rst_n) // R20
    wr_ndata && nsel_q == NSEL_TOP |=>
    div_n_q == {$past(io_wdata), stage_q[2], stage_q[1], stage_q[0]})
    else $error("top nibble write did not commit division number");
  a_nibble_hold: assert property (@(posedge clk) disable iff (!rst_n) // R20
    wr_ndata && nsel_q != NSEL_TOP |=> $stable(div_n_q))
    else $error("division number changed before top nibble");
  a_select_step: assert property (@(posedge clk) disable iff (!rst_n) // R21
    acc_ndata |=> nsel_q == $past(nsel_q) + 2'h1)
    else $error("nibble select did not advance");
  a_off_float: assert property (@(posedge clk) disable iff (!rst_n) // R19
    pll_off && !do1_q.gen_out |=> !phase_out_primary_oe && !phase_out_secondary_oe)
    else $error("phase output driven while PLL off");
  a_gen_out_drive: assert property (@(posedge clk) disable iff (!rst_n) // R11
    do1_q.gen_out |=> phase_out_primary_oe && phase_out_primary_o == $past(do1_q.level))
    else $error("general output level not driven");
  a_off_pulldown: assert property (@(posedge clk) disable iff (!rst_n) // R6
    pll_off |=> low_band_pulldown && high_band_pulldown)
    else $error("band inputs not pulled down while off");
  a_unlock_sticky: assert property (@(posedge clk) disable iff (!rst_n) // R12
    unlock_set ##1 !lock_clr [*2] |=> unlock_q)
    else $error("unlock flag lost");
  a_clear_valid: assert property (@(posedge clk) disable iff (!rst_n) // R13
    lock_clr |=> !valid_q ##1 !valid_q)
    else $error("valid bit survived the clear");
  a_valid_wait: assert property (@(posedge clk) disable iff (!rst_n) // R14
    $rose(valid_q) |-> $past(ref_pulse_q) && $past(seen_q))
    else $error("valid set before a full reference cycle");
  a_bin_top_zero: assert property (@(posedge clk) disable iff (!rst_n) // R15
    io_rd && io_chan == CH_LOCK |=> io_rdata[3] == 1'b0)
    else $error("phase bin top bit not zero");
  a_off_halts: assert property (@(posedge clk) disable iff (!rst_n) // R8
    pll_off [*2] |-> !ref_pulse_q && !div_pulse_q)
    else $error("counter ran while PLL off");

  c_commit: cover property (@(posedge clk) disable iff (!rst_n)
    wr_ndata && nsel_q == NSEL_TOP);
  c_unlock: cover property (@(posedge clk) disable iff (!rst_n) $rose(unlock_q));
  c_valid: cover property (@(posedge clk) disable iff (!rst_n) $rose(valid_q));
  c_bin_far: cover property (@(posedge clk) disable iff (!rst_n) bin == 3'h7);
endmodule : pls_synth

/* hw/pls_pkg.sv */
// Purpose: shared constants and types of the tuning synthesizer digital core
// Assumes: 100 MHz system clock, 75 kHz crystal arrives as a one-cycle tick
// Notes: channel codes select the internal ports of the first in/out group
package pls_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // phase-error bin step and half step, in ns
  localparam int PHASE_STEP_NS = 13300;
  localparam int PHASE_HALF_NS = 6660;
  localparam int PHASE_STEP_CYC = PHASE_STEP_NS / CLK_PERIOD_NS;
  localparam int PHASE_HALF_CYC = PHASE_HALF_NS / CLK_PERIOD_NS;

  localparam logic [3:0] CH_MODE = 4'h0;
  localparam logic [3:0] CH_NSEL = 4'h1;
  localparam logic [3:0] CH_NDATA = 4'h2;
  localparam logic [3:0] CH_REF = 4'h3;
  localparam logic [3:0] CH_PRE = 4'h4;
  localparam logic [3:0] CH_DO1 = 4'h7;
  localparam logic [3:0] CH_LOCK = 4'h8;

  localparam logic [1:0] NSEL_TOP = 2'h3;
  localparam logic [15:0] DIV_MIN = 16'h0210;
  localparam logic [15:0] DIV_MAX = 16'hFFFF;
  localparam logic [15:0] DIV_RST = 16'h0000;

  localparam logic [3:0] REF_OFF = 4'hF;
  localparam logic [3:0] REF_RST = 4'hF;
  // crystal ticks per reference period for codes 0..6
  localparam logic [6:0] REF_DIV_1K = 7'h4B;
  localparam logic [6:0] REF_DIV_3K = 7'h19;
  localparam logic [6:0] REF_DIV_3K125 = 7'h18;
  localparam logic [6:0] REF_DIV_5K = 7'h0F;
  localparam logic [6:0] REF_DIV_6K25 = 7'h0C;
  localparam logic [6:0] REF_DIV_12K5 = 7'h06;
  localparam logic [6:0] REF_DIV_25K = 7'h03;

  localparam logic [1:0] PRE_NONE = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV8 = 2'h2;

  typedef struct packed {
    logic if_dn;
    logic if_up;
    logic swallow;
  } pls_mode_s;

  typedef struct packed {
    logic hiz;
    logic level;
    logic gen_out;
  } pls_do1_s;

  localparam pls_mode_s MODE_RST = 3'h0;
  localparam pls_do1_s DO1_RST = 3'h0;

  function automatic logic [6:0] pls_ref_div(input logic [3:0] sel);
    case (sel)
      4'h0: pls_ref_div = REF_DIV_1K;
      4'h1: pls_ref_div = REF_DIV_3K;
      4'h2: pls_ref_div = REF_DIV_3K125;
      4'h3: pls_ref_div = REF_DIV_5K;
      4'h4: pls_ref_div = REF_DIV_6K25;
      4'h5: pls_ref_div = REF_DIV_12K5;
      4'h6: pls_ref_div = REF_DIV_25K;
      default: pls_ref_div = REF_DIV_1K;
    endcase
  endfunction : pls_ref_div
endpackage : pls_pkg

/* hw/pls_phase_det.sv */
// Purpose: phase-frequency detector with phase-error bin measurement
// Assumes: ref_pulse and div_pulse are one-cycle pulses on clk
// Notes: bin is taken when each error pulse ends; aligned edges give bin 0
`timescale 1ns/1ns
module pls_phase_det
  import pls_pkg::*;
#(
  parameter int STEP_CYC = PHASE_STEP_CYC,
  parameter int HALF_CYC = PHASE_HALF_CYC
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic ref_pulse,
  input wire logic div_pulse,
  output logic up_q,
  output logic dn_q,
  output logic [2:0] bin_q
);
  localparam int SW = $clog2(STEP_CYC + 1);
  logic up_d;
  logic dn_d;
  logic meas_q;
  logic [SW-1:0] sub_q;
  logic [2:0] acc_q;

  assign up_d = up_q | ref_pulse;
  assign dn_d = dn_q | div_pulse;

  // ref first: divider lags; divider first: divider leads
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end
    else if (!run || (up_d && dn_d))
    begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end
    else
    begin
      up_q <= up_d; // R25
      dn_q <= dn_d; // R25
    end
  end

  // negative side starts at bin 1, positive side is offset by half a step
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meas_q <= 1'b0;
      sub_q <= '0;
      acc_q <= 3'h0;
      bin_q <= 3'h0;
    end
    else if (!run)
    begin
      meas_q <= 1'b0;
    end
    else if (!meas_q)
    begin
      if (ref_pulse && div_pulse)
        bin_q <= 3'h0; // R16
      else if (ref_pulse || div_pulse)
      begin
        meas_q <= 1'b1;
        acc_q <= div_pulse ? 3'h1 : 3'h0; // R15
        sub_q <= div_pulse ? '0 : SW'(STEP_CYC - HALF_CYC); // R15
      end
    end
    else if (up_d && dn_d)
    begin
      meas_q <= 1'b0;
      bin_q <= acc_q; // R16
    end
    else if (sub_q == SW'(STEP_CYC - 1))
    begin
      sub_q <= '0;
      if (acc_q != 3'h7)
        acc_q <= acc_q + 3'h1; // R15
    end
    else
      sub_q <= sub_q + SW'(1);
  end

  a_bin_zero_aligned: assert property (@(posedge clk) disable iff (!rst_n)
    run && !meas_q && ref_pulse && div_pulse |=> bin_q == 3'h0) // R16
    else $error("aligned edges did not give bin zero");
endmodule : pls_phase_det

/* verif/pls_prescaler_model.sv */
// Purpose: behavioural two-modulus prescaler driven by a free-running vco
// Assumes: one vco cycle per clk while run is high
// Notes: output rests low while stopped; edge_cnt counts rising edges shown
`timescale 1ns/1ns
module pls_prescaler_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic mod_ctrl,
  output logic band_out,
  output logic [15:0] edge_cnt
);
  logic [3:0] ph_q;

  // modulus is picked at the wrap so a late mod_ctrl change cuts no pulse short
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q <= 4'h0;
      edge_cnt <= 16'h0000;
    end
    else if (!run)
    begin
      ph_q <= 4'h0;
      edge_cnt <= 16'h0000;
    end
    else
    begin
      ph_q <= (ph_q == (mod_ctrl ? 4'hE : 4'hF)) ? 4'h0 : ph_q + 4'h1;
      if (ph_q == 4'h0)
        edge_cnt <= edge_cnt + 16'h0001;
    end
  end

  assign band_out = run && (ph_q < 4'h4);
endmodule : pls_prescaler_model

/* verif/pls_synth_tb.sv */
// Purpose: self-checking bench of the synthesizer digital core
// Assumes: crystal tick every 8 clk cycles to keep reference periods short
// Notes: divider counts are seen as the first phase pulse with no reference tick
`timescale 1ns/1ns
module pls_synth_tb;
  import pls_pkg::*;
  logic clk, rst_n, xtal_tick, io_wr, io_rd, tick_en, vco_run, prs_out;
  logic [3:0] io_chan, io_wdata, io_rdata, d;
  logic mod_ctrl, low_pd, high_pd, pri_o, pri_oe, sec_o, sec_oe;
  logic low_band_input, high_band_input;
  logic [15:0] prs_edges;
  logic [2:0] tick_ph;
  logic [31:0] rng, r;
  int err_total, checks_done, tick_cnt, i, c, k, t0, n_hi, n_sec;
  int ref_ticks [7] = '{75, 25, 24, 15, 12, 6, 3};

  assign low_band_input = low_pd ? 1'b0 : prs_out;
  assign high_band_input = high_pd ? 1'b0 : prs_out;

  pls_synth u_pls_synth (.clk(clk), .rst_n(rst_n), .xtal_tick(xtal_tick),
    .low_band_input(low_band_input), .high_band_input(high_band_input),
    .io_wr(io_wr), .io_rd(io_rd), .io_chan(io_chan), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .prescaler_mod_ctrl(mod_ctrl), .low_band_pulldown(low_pd),
    .high_band_pulldown(high_pd), .phase_out_primary_o(pri_o),
    .phase_out_primary_oe(pri_oe), .phase_out_secondary_o(sec_o),
    .phase_out_secondary_oe(sec_oe));

  pls_prescaler_model u_pls_prescaler_model (.clk(clk), .rst_n(rst_n), .run(vco_run),
    .mod_ctrl(mod_ctrl), .band_out(prs_out), .edge_cnt(prs_edges));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk)
  begin
    // held at zero in reset so the phase never starts from an unknown
    tick_ph <= rst_n ? tick_ph + 3'h1 : 3'h0;
    xtal_tick <= tick_en && (tick_ph == 3'h7);
  end

  always @(posedge clk)
    if (!rst_n)
      tick_cnt <= 0;
    else if (xtal_tick)
      tick_cnt <= tick_cnt + 1;

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xorshift

  // effective division number after the offset bits, swallow mode only
  function automatic logic [15:0] n_eff(input logic sw, input logic [1:0] off,
    input logic [15:0] n);
    if (!sw || off == 2'h0 || off == 2'h3)
      return n;
    return (off == 2'h1) ? n + 16'h0001 : n - 16'h0001;
  endfunction : n_eff

  task automatic stop_test();
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic io_wrt(input logic [3:0] ch, input logic [3:0] v);
    @(negedge clk);
    io_wr = 1'b1;
    io_chan = ch;
    io_wdata = v;
    @(negedge clk);
    io_wr = 1'b0;
  endtask : io_wrt

  task automatic io_get(input logic [3:0] ch, output logic [3:0] v);
    @(negedge clk);
    io_rd = 1'b1;
    io_chan = ch;
    @(negedge clk);
    io_rd = 1'b0;
    v = io_rdata;
  endtask : io_get

  task automatic run_count(input logic sw, input logic [1:0] pre, input logic [1:0] off,
    input logic [15:0] n);
    logic [15:0] n2;
    int exp;
    int j;
    n2 = n_eff(sw, off, n);
    exp = (sw ? (pre == 2'h1 ? 4 : (pre == 2'h2 ? 8 : 1)) : 1) * int'(n2[15:4]);
    io_wrt(CH_REF, REF_OFF);
    io_wrt(CH_MODE, {1'b0, off, sw});
    io_wrt(CH_PRE, {2'b00, pre});
    io_wrt(CH_NSEL, 4'h0);
    for (j = 0; j < 4; j++)
      io_wrt(CH_NDATA, n[4*j+:4]);
    // three nibbles without the top one must leave the number alone
    io_wrt(CH_NSEL, 4'h0);
    for (j = 0; j < 3; j++)
      io_wrt(CH_NDATA, ~n[4*j+:4]);
    io_wrt(CH_REF, 4'h0);
    // pulldowns are registered one cycle behind the reference code
    @(negedge clk);
    chk("pulldowns on", sw ? 16'h2 : 16'h1, {14'h0, low_pd, high_pd});
    chk("mod ctrl", {15'h0, sw && (n2[3:0] != 4'h0)}, {15'h0, mod_ctrl});
    @(negedge clk);
    vco_run = 1'b1;
    for (j = 0; j < 9000 && sec_oe !== 1'b1; j++)
      @(negedge clk);
    if (j == 9000)
    begin
      err_total++;
      stop_test();
    end
    chk("divider edges", exp[15:0], prs_edges);
    chk("lead level", 16'h3, {14'h0, pri_oe, ~sec_o});
    vco_run = 1'b0;
    io_wrt(CH_REF, REF_OFF);
    repeat (3) @(negedge clk);
    chk("off outputs", 16'h0, {14'h0, pri_oe, sec_oe});
    chk("off pulldowns", 16'h3, {14'h0, low_pd, high_pd});
  endtask : run_count

  initial
  begin
    rng = 32'h215c;
    {err_total, checks_done} = '0;
    {tick_en, vco_run, io_wr, io_rd, rst_n} = '0;
    {io_chan, io_wdata} = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk("reset pulldowns", 16'h3, {14'h0, low_pd, high_pd});
    chk("reset oe", 16'h0, {14'h0, pri_oe, sec_oe});
    io_get(CH_REF, d);
    chk("reset ref code", {12'h0, REF_OFF}, {12'h0, d});
    r = xorshift();
    io_wrt(CH_MODE, {1'b0, r[2:0]});
    io_get(CH_MODE, d);
    chk("mode readback", {13'h0, r[2:0]}, {12'h0, d});
    io_wrt(CH_PRE, r[5] ? 4'h2 : {3'h0, r[4]});
    io_get(CH_PRE, d);
    chk("pre readback", r[5] ? 16'h2 : {15'h0, r[4]}, {12'h0, d});
    io_wrt(CH_NSEL, {2'b00, r[9:8]});
    io_get(CH_NDATA, d);
    io_get(CH_NSEL, d);
    chk("select advance", {14'h0, r[9:8] + 2'h1}, {14'h0, d[1:0]});
    io_wrt(4'h5, 4'hF);
    io_get(4'h5, d);
    chk("unmapped read", 16'h0, {12'h0, d});
    run_count(1'b1, 2'h0, 2'h2, DIV_MIN);
    for (i = 0; i < 8; i++)
    begin
      r = xorshift();
      run_count(i[0], r[5] ? 2'h2 : {1'b0, r[4]}, i[2:1],
        {4'h0, 8'h21 + {5'h0, r[2:0]}, r[11:8]});
    end
    @(posedge clk);
    tick_en = 1'b1;
    for (c = 0; c < 7; c++)
    begin
      io_wrt(CH_REF, REF_OFF);
      io_wrt(CH_REF, c[3:0]);
      io_wrt(CH_LOCK, 4'h1);
      t0 = tick_cnt;
      io_get(CH_DO1, d);
      chk("valid after clear", 16'h0, {15'h0, d[1]});
      if (c == 0)
        chk("unlock after clear", 16'h0, {15'h0, d[0]});
      for (k = 0; k < 1000 && d[1] !== 1'b1; k++)
        io_get(CH_DO1, d);
      if (k == 1000)
      begin
        err_total++;
        stop_test();
      end
      t0 = tick_cnt - t0;
      chk("ref period", 16'h1, {15'h0, t0 >= ref_ticks[c] - 1 && t0 <= 2 * ref_ticks[c] + 1});
      chk("unlock set", 16'h1, {15'h0, d[0]});
      io_get(CH_LOCK, d);
      chk("bin top bit", 16'h0, {15'h0, d[3]});
    end
    r = xorshift();
    io_wrt(CH_DO1, {2'b00, r[0], 1'b1});
    repeat (3) @(negedge clk);
    chk("general out", {14'h0, 1'b1, r[0]}, {14'h0, pri_oe, pri_o});
    io_wrt(CH_REF, REF_OFF);
    repeat (3) @(negedge clk);
    chk("general out off", {13'h0, 1'b1, r[0], 1'b0}, {13'h0, pri_oe, pri_o, sec_oe});
    io_wrt(CH_DO1, 4'h4);
    io_wrt(CH_REF, 4'h6);
    {n_hi, n_sec} = '0;
    repeat (80)
    begin
      @(negedge clk);
      if (pri_oe !== 1'b0)
        n_hi++;
      if (sec_oe === 1'b1)
        n_sec++;
    end
    chk("forced float", 16'h0, n_hi[15:0]);
    chk("secondary active", 16'h1, {15'h0, n_sec > 0});
    io_wrt(CH_DO1, 4'h0);
    repeat (40) @(negedge clk);
    chk("lag level", 16'hF, {12'h0, pri_oe, pri_o, sec_oe, sec_o});
    stop_test();
  end
endmodule : pls_synth_tb
